// ### shared/acalo_pkg.sv
// Shared constants, types and field layouts for the add-carry / logic-op execution block.
// What this block does
// - Add-with-carry sums accumulator, file and carry, sets flags.
// - Destination bit 0 writes sum to accumulator.
// - Destination bit 1 writes sum to file.
// - Bank bit 0 selects the access bank.
// - Bank bit 1 uses bank select register.
// - Extended set, bank 0, address up to 5F: indexed.
// - AND literal into accumulator, updates only negative, zero.
// - AND accumulator with file to chosen destination.
package acalo_pkg;

  // Opcode patterns
  localparam logic [5:0] ACALO_OPC_ADD_WITH_CARRY_TO_FILE = 6'h08;
  localparam logic [7:0] ACALO_OPC_AND_LITERAL_TO_ACCUMULATOR = 8'h0b;
  localparam logic [5:0] ACALO_OPC_AND_ACCUMULATOR_WITH_FILE = 6'h05;

  // Instruction field positions
  localparam int unsigned ACALO_DEST_BIT = 9;
  localparam int unsigned ACALO_BANK_BIT = 8;

  // Highest file address that the indexed mode and low access bank cover
  localparam logic [7:0] ACALO_INDEX_LIMIT = 8'h5f;
  localparam logic [3:0] ACALO_ACCESS_HIGH_PAGE = 4'hf;

  // Register bus offsets
  localparam logic [3:0] ACALO_REG_ACCUMULATOR = 4'h0;
  localparam logic [3:0] ACALO_REG_STATUS = 4'h1;
  localparam logic [3:0] ACALO_REG_BANK_SELECT = 4'h2;
  localparam logic [3:0] ACALO_REG_CONTROL = 4'h3;
  localparam logic [3:0] ACALO_REG_INDEX_LOW = 4'h4;
  localparam logic [3:0] ACALO_REG_INDEX_HIGH = 4'h5;

  // Reset values
  localparam logic [7:0] ACALO_RST_ACCUMULATOR = 8'h00;
  localparam logic [4:0] ACALO_RST_STATUS = 5'h00;
  localparam logic [3:0] ACALO_RST_BANK_SELECT = 4'h0;
  localparam logic ACALO_RST_EXTENDED = 1'b0;
  localparam logic [11:0] ACALO_RST_INDEX_BASE = 12'h000;

  // Status flags, bit 4 down to bit 0 of the status register
  typedef struct packed {
    logic negative;
    logic overflow_flag;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } acalo_flags_t;

  // Data memory request, one cycle per strobe
  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [11:0] addr;
    logic [7:0] wr_data;
  } acalo_mem_req_t;

  typedef enum logic [1:0] {
    ACALO_ALU_ADDC = 2'b00,
    ACALO_ALU_AND = 2'b01
  } acalo_alu_op_t;

  typedef enum logic [1:0] {
    ACALO_KIND_NONE = 2'b00,
    ACALO_KIND_ADDC_FILE = 2'b01,
    ACALO_KIND_AND_LITERAL = 2'b10,
    ACALO_KIND_AND_FILE = 2'b11
  } acalo_kind_t;

  // Four phases of one instruction cycle plus idle
  typedef enum logic [2:0] {
    ACALO_ST_IDLE = 3'b000,
    ACALO_ST_DECODE = 3'b001,
    ACALO_ST_READ = 3'b010,
    ACALO_ST_PROCESS = 3'b011,
    ACALO_ST_WRITE = 3'b100
  } acalo_state_t;

endpackage

// ### verilog/acalo_alu.sv
// Combinational arithmetic and logic unit with flag generation.
`timescale 1ns/1ps
module acalo_alu
  import acalo_pkg::*;
(
  input acalo_alu_op_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] operand,
  input wire logic carry_in,
  input acalo_flags_t flags_in,
  output logic [7:0] result,
  output acalo_flags_t flags_out
);

  logic [8:0] sum;
  logic [4:0] low_sum;

  // Full and nibble sums; nibble carry gives the digit carry
  always_comb begin
    sum = {1'b0, acc} + {1'b0, operand} + {8'h00, carry_in};
    low_sum = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, carry_in};
    flags_out = flags_in;
    if (op == ACALO_ALU_ADDC) begin
      result = sum[7:0];
      flags_out.carry = sum[8];
      flags_out.digit_carry_flag = low_sum[4];
      // Signed overflow: like-signed inputs, differently signed result
      flags_out.overflow_flag = (acc[7] == operand[7]) && (sum[7] != acc[7]);
    end else begin
      // Logic ops leave carry, digit carry and overflow untouched
      result = acc & operand;
    end
    flags_out.negative = result[7];
    flags_out.zero = (result == 8'h00);
  end

endmodule

// ### verilog/acalo_core.sv
// Execution block for add-with-carry and the two AND instructions, with register port.
`timescale 1ns/1ps
module acalo_core
  import acalo_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  output acalo_mem_req_t mem_req,
  input wire logic [7:0] mem_rd_data,
  output logic done,
  output logic unsupported,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);

  // Resolve an 8-bit file address into a 12-bit data address
  function automatic logic [11:0] acalo_resolve(
    input logic [7:0] f,
    input logic bank,
    input logic ext,
    input logic [3:0] bank_select_register,
    input logic [11:0] base
  );
    logic [11:0] addr;
    addr = {ACALO_ACCESS_HIGH_PAGE, f};
    if (bank) begin
      addr = {bank_select_register, f};
    end else if (ext && (f <= ACALO_INDEX_LIMIT)) begin
      addr = base + {4'h0, f};
    end else if (f <= ACALO_INDEX_LIMIT) begin
      addr = {4'h0, f};
    end
    return addr;
  endfunction

  // Classify an instruction word
  function automatic acalo_kind_t acalo_classify(input logic [15:0] w);
    acalo_kind_t k;
    k = ACALO_KIND_NONE;
    if (w[15:10] == ACALO_OPC_ADD_WITH_CARRY_TO_FILE) begin
      k = ACALO_KIND_ADDC_FILE;
    end else if (w[15:8] == ACALO_OPC_AND_LITERAL_TO_ACCUMULATOR) begin
      k = ACALO_KIND_AND_LITERAL;
    end else if (w[15:10] == ACALO_OPC_AND_ACCUMULATOR_WITH_FILE) begin
      k = ACALO_KIND_AND_FILE;
    end
    return k;
  endfunction

  acalo_state_t state_q, state_d;
  acalo_kind_t kind_q, kind_d;
  logic [15:0] instr_q, instr_d;
  logic ready_q, ready_d;
  logic done_q, done_d;
  logic unsup_q, unsup_d;
  acalo_mem_req_t mem_req_q, mem_req_d;
  logic [11:0] addr_q, addr_d;

  logic [7:0] acc_q, acc_d;
  acalo_flags_t flags_q, flags_d;
  logic [3:0] bsr_q, bsr_d;
  logic ext_q, ext_d;
  logic [11:0] base_q, base_d;
  logic [7:0] rdata_q, rdata_d;

  acalo_alu_op_t alu_op;
  logic [7:0] alu_operand;
  logic [7:0] alu_result;
  acalo_flags_t alu_flags;

  // Operand source: the literal for AND-literal, otherwise the file byte just read
  always_comb begin
    alu_op = (kind_q == ACALO_KIND_ADDC_FILE) ? ACALO_ALU_ADDC : ACALO_ALU_AND;
    alu_operand = (kind_q == ACALO_KIND_AND_LITERAL) ? instr_q[7:0] : mem_rd_data;
  end

  acalo_alu u_alu (
    .op(alu_op),
    .acc(acc_q),
    .operand(alu_operand),
    .carry_in(flags_q.carry & (kind_q == ACALO_KIND_ADDC_FILE)),
    .flags_in(flags_q),
    .result(alu_result),
    .flags_out(alu_flags)
  );

  // Sequencer through the four phases
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    instr_d = instr_q;
    addr_d = addr_q;
    done_d = 1'b0;
    unsup_d = 1'b0;
    mem_req_d = '0;
    case (state_q)
      ACALO_ST_IDLE: begin
        if (instr_valid && ready_q) begin
          instr_d = instr_word;
          state_d = ACALO_ST_DECODE;
        end
      end
      ACALO_ST_DECODE: begin
        kind_d = acalo_classify(instr_q);
        // Shared addressing for both file ops
        addr_d = acalo_resolve(instr_q[7:0], instr_q[ACALO_BANK_BIT], ext_q, bsr_q, base_q);
        if (kind_d == ACALO_KIND_NONE) begin
          // Foreign opcodes are dropped without side effects
          unsup_d = 1'b1;
          state_d = ACALO_ST_IDLE;
        end else begin
          if (kind_d != ACALO_KIND_AND_LITERAL) begin
            mem_req_d.rd_en = 1'b1;
            mem_req_d.addr = addr_d;
          end
          state_d = ACALO_ST_READ;
        end
      end
      ACALO_ST_READ: begin
        // File byte returns in the cycle after the read strobe
        state_d = ACALO_ST_PROCESS;
      end
      ACALO_ST_PROCESS: begin
        if ((kind_q != ACALO_KIND_AND_LITERAL) && instr_q[ACALO_DEST_BIT]) begin
          mem_req_d.wr_en = 1'b1;
          mem_req_d.addr = addr_q;
          mem_req_d.wr_data = alu_result;
        end
        done_d = 1'b1;
        state_d = ACALO_ST_WRITE;
      end
      ACALO_ST_WRITE: begin
        state_d = ACALO_ST_IDLE;
      end
      default: begin
        state_d = ACALO_ST_IDLE;
      end
    endcase
    ready_d = (state_d == ACALO_ST_IDLE);
  end

  // Sequencer registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ACALO_ST_IDLE;
      kind_q <= ACALO_KIND_NONE;
      instr_q <= 16'h0000;
      addr_q <= 12'h000;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      unsup_q <= 1'b0;
      mem_req_q <= '0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      instr_q <= instr_d;
      addr_q <= addr_d;
      ready_q <= ready_d;
      done_q <= done_d;
      unsup_q <= unsup_d;
      mem_req_q <= mem_req_d;
    end
  end

  // Architectural state and register port; the commit comes last so it wins over software
  always_comb begin
    acc_d = acc_q;
    flags_d = flags_q;
    bsr_d = bsr_q;
    ext_d = ext_q;
    base_d = base_q;
    rdata_d = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        ACALO_REG_ACCUMULATOR: acc_d = reg_wdata;
        ACALO_REG_STATUS: flags_d = reg_wdata[4:0];
        ACALO_REG_BANK_SELECT: bsr_d = reg_wdata[3:0];
        ACALO_REG_CONTROL: ext_d = reg_wdata[0];
        ACALO_REG_INDEX_LOW: base_d = {base_q[11:8], reg_wdata};
        ACALO_REG_INDEX_HIGH: base_d = {reg_wdata[3:0], base_q[7:0]};
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      // Unmapped offsets read as zero
      case (reg_addr)
        ACALO_REG_ACCUMULATOR: rdata_d = acc_q;
        ACALO_REG_STATUS: rdata_d = {3'h0, flags_q};
        ACALO_REG_BANK_SELECT: rdata_d = {4'h0, bsr_q};
        ACALO_REG_CONTROL: rdata_d = {7'h00, ext_q};
        ACALO_REG_INDEX_LOW: rdata_d = base_q[7:0];
        ACALO_REG_INDEX_HIGH: rdata_d = {4'h0, base_q[11:8]};
        default: rdata_d = 8'h00;
      endcase
    end
    if (state_q == ACALO_ST_PROCESS) begin
      flags_d = alu_flags;
      if ((kind_q == ACALO_KIND_AND_LITERAL) || !instr_q[ACALO_DEST_BIT]) begin
        acc_d = alu_result;
      end
    end
  end

  // Architectural registers
  always_ff @(posedge clock) begin
    if (rst) begin
      acc_q <= ACALO_RST_ACCUMULATOR;
      flags_q <= ACALO_RST_STATUS;
      bsr_q <= ACALO_RST_BANK_SELECT;
      ext_q <= ACALO_RST_EXTENDED;
      base_q <= ACALO_RST_INDEX_BASE;
      rdata_q <= 8'h00;
    end else begin
      acc_q <= acc_d;
      flags_q <= flags_d;
      bsr_q <= bsr_d;
      ext_q <= ext_d;
      base_q <= base_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flops
  assign instr_ready = ready_q;
  assign mem_req = mem_req_q;
  assign done = done_q;
  assign unsupported = unsup_q;
  assign reg_rdata = rdata_q;

endmodule

// ### dv/acalo_core_sva.sv
// Checker for the execution block's instruction, memory and register ports.
`timescale 1ns/1ps
module acalo_core_sva
  import acalo_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic instr_ready,
  input acalo_mem_req_t mem_req,
  input wire logic done,
  input wire logic unsupported,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Opcode classes of the word being taken
  logic take, addc, andl, fop;
  assign take = instr_valid && instr_ready;
  assign addc = instr_word[15:10] == ACALO_OPC_ADD_WITH_CARRY_TO_FILE;
  assign andl = instr_word[15:8] == ACALO_OPC_AND_LITERAL_TO_ACCUMULATOR;
  assign fop = addc || instr_word[15:10] == ACALO_OPC_AND_ACCUMULATOR_WITH_FILE;

  a_addc_commit: assert property (take && addc |-> ##4 done) else $error("add commit late");
  a_file_read: assert property (take && fop |-> ##2 mem_req.rd_en) else $error("no file read");
  a_dest_acc: assert property (take && fop && !instr_word[ACALO_DEST_BIT] |-> ##4 done && !mem_req.wr_en)
    else $error("file written for accumulator dest");
  a_dest_file: assert property (take && fop && instr_word[ACALO_DEST_BIT] |->
    ##4 done && mem_req.wr_en && mem_req.addr == $past(mem_req.addr, 2)) else $error("file write wrong");
  a_bank_reg: assert property (take && fop && instr_word[ACALO_BANK_BIT] |->
    ##2 mem_req.addr[7:0] == $past(instr_word[7:0], 2)) else $error("banked address wrong");
  a_access_high: assert property (take && fop && !instr_word[8] && instr_word[7:0] > ACALO_INDEX_LIMIT |->
    ##2 mem_req.addr == {ACALO_ACCESS_HIGH_PAGE, $past(instr_word[7:0], 2)}) else $error("access address wrong");
  a_lit_noread: assert property (take && andl |-> ##2 !mem_req.rd_en ##2 done && !mem_req.wr_en)
    else $error("literal op touched memory");
  // Supported ops hold off the next word through commit; a refused word frees the port a cycle after decode
  a_busy_hold: assert property (take && (fop || andl) |=> !instr_ready [*4] ##1 instr_ready)
    else $error("ready while busy");
  a_unsup_ready: assert property (take && !fop && !andl |=> !instr_ready ##1 instr_ready)
    else $error("ready wrong after refusal");
  a_unsup_pulse: assert property (take && !fop && !andl |-> ##2 unsupported && !mem_req.rd_en)
    else $error("unsupported not flagged");
  a_read_slot: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside slot");

  c_addc: cover property (take && addc);
  c_andl: cover property (take && andl);
  c_unsup: cover property (unsupported);
endmodule

bind acalo_core acalo_core_sva i_acalo_core_sva (.clock, .rst, .instr_valid, .instr_word, .instr_ready,
  .mem_req, .done, .unsupported, .reg_rd, .reg_rdata);

// ### dv/acalo_mem_model.sv
// Data memory file answering the block's read and write strobes.
`timescale 1ns/1ps
module acalo_mem_model
  import acalo_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input acalo_mem_req_t mem_req,
  output logic [7:0] mem_rd_data
);
  logic [7:0] mem [4096];
  // Data stands one cycle; toggling otherwise exposes a late sample
  always @(posedge clock) begin
    if (rst) begin
      mem_rd_data <= 8'h5a;
    end else if (mem_req.rd_en) begin
      mem_rd_data <= mem[mem_req.addr];
    end else begin
      mem_rd_data <= ~mem_rd_data;
    end
    if (mem_req.wr_en) begin
      mem[mem_req.addr] <= mem_req.wr_data;
    end
  end
endmodule

// ### dv/acalo_core_tb_top.sv
// Testbench running instructions and register accesses through the block.
`timescale 1ns/1ps
module acalo_core_tb_top
  import acalo_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic instr_ready, done, unsupported, saw_unsup;
  logic [7:0] mem_rd_data, reg_rdata;
  acalo_mem_req_t mem_req;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #5 clock = ~clock;

  acalo_core i_acalo_core (.clock, .rst, .instr_valid, .instr_word, .instr_ready, .mem_req, .mem_rd_data,
    .done, .unsupported, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  acalo_mem_model i_acalo_mem_model (.clock, .rst, .mem_req, .mem_rd_data);

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Register port: one-cycle strobes, read data in the following cycle only
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk(nm, reg_rdata, exp);
  endtask

  // Offer a word, hold it until taken, then wait for commit or refusal
  task automatic exec(input logic [15:0] w);
    int i;
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word <= w;
    i = 0;
    do begin @(negedge clock); i++; end while (instr_ready !== 1'b1 && i < 20);
    // A port that never frees counts as a failure, like a missing commit
    if (instr_ready !== 1'b1) begin
      n_mismatch++;
      conclude();
    end else begin
      @(posedge clock);
      instr_valid <= 1'b0;
      for (i = 0; i < 8 && done !== 1'b1 && unsupported !== 1'b1; i++) @(negedge clock);
      saw_unsup = unsupported;
      if (i == 8) begin
        n_mismatch++;
        conclude();
      end
    end
  endtask

  initial begin
    int k;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    // Reset values, offset 6 unmapped
    for (k = 0; k < 7; k++) rd(k[3:0], 8'h00, "reset");
    wr(4'h6, 8'hff);
    rd(4'h6, 8'h00, "unmapped");
    $display("test reset_values done");
    // Banked add with carry in, sum to accumulator
    wr(ACALO_REG_ACCUMULATOR, 8'h4d);
    wr(ACALO_REG_STATUS, 8'h01);
    wr(ACALO_REG_BANK_SELECT, 8'h03);
    i_acalo_mem_model.mem[12'h340] = 8'h02;
    exec(16'h2140);
    rd(ACALO_REG_ACCUMULATOR, 8'h50, "sum");
    rd(ACALO_REG_STATUS, 8'h02, "sum flags");
    chk("file kept", i_acalo_mem_model.mem[12'h340], 8'h02);
    $display("test add_to_accumulator done");
    // Access-bank add to file: wrap gives zero, carry, overflow
    wr(ACALO_REG_STATUS, 8'h00);
    wr(ACALO_REG_ACCUMULATOR, 8'h80);
    i_acalo_mem_model.mem[12'hf80] = 8'h80;
    exec(16'h2280);
    rd(ACALO_REG_ACCUMULATOR, 8'h80, "acc kept");
    rd(ACALO_REG_STATUS, 8'h0d, "wrap flags");
    // File write lands the cycle after commit, so look after the reads
    chk("file sum", i_acalo_mem_model.mem[12'hf80], 8'h00);
    $display("test add_to_file done");
    // Indexed mode at the limit, then just above it
    wr(ACALO_REG_CONTROL, 8'h01);
    wr(ACALO_REG_INDEX_LOW, 8'h20);
    wr(ACALO_REG_INDEX_HIGH, 8'h01);
    wr(ACALO_REG_ACCUMULATOR, 8'h17);
    i_acalo_mem_model.mem[12'h17f] = 8'hc2;
    i_acalo_mem_model.mem[12'hf60] = 8'h80;
    exec(16'h165f);
    rd(ACALO_REG_STATUS, 8'h09, "and flags");
    rd(ACALO_REG_ACCUMULATOR, 8'h17, "acc kept and");
    chk("indexed and", i_acalo_mem_model.mem[12'h17f], 8'h02);
    exec(16'h1460);
    rd(ACALO_REG_ACCUMULATOR, 8'h00, "and to acc");
    rd(ACALO_REG_STATUS, 8'h0d, "and zero");
    $display("test and_with_file done");
    // Literal AND leaves carry and overflow alone
    wr(ACALO_REG_ACCUMULATOR, 8'ha3);
    exec(16'h0bf0);
    rd(ACALO_REG_ACCUMULATOR, 8'ha0, "and literal");
    rd(ACALO_REG_STATUS, 8'h19, "literal flags");
    $display("test and_literal done");
    // Foreign opcode has no effect
    exec(16'hffff);
    chk("unsupported", {7'h00, saw_unsup}, 8'h01);
    rd(ACALO_REG_ACCUMULATOR, 8'ha0, "acc after refusal");
    $display("test unsupported done");
    conclude();
  end
endmodule
